// ===== bbc_pkg.sv
package bbc_pkg;
  // ****************************************
  // Bus widths and address map
  // ****************************************
  localparam int unsigned BBC_ADDR_W  = 20;
  localparam int unsigned BBC_DATA_W  = 16;
  localparam int unsigned BBC_PAGE_W  = 8;
  localparam int unsigned BBC_PAGE_SH = 12;
  localparam int unsigned BBC_PCS_SH  = 9;
  localparam logic [19:0] BBC_PCS_BASE = 20'hffc00;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] BBC_OFF_CTRL   = 8'h00;
  localparam logic [7:0] BBC_OFF_LOWER  = 8'h04;
  localparam logic [7:0] BBC_OFF_UPPER  = 8'h08;
  localparam logic [7:0] BBC_OFF_BIAS   = 8'h0c;
  localparam logic [7:0] BBC_OFF_STATUS = 8'h10;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int unsigned BBC_CTRL_ATTN   = 0;
  localparam int unsigned BBC_CTRL_PROG   = 1;
  localparam int unsigned BBC_CTRL_PREFRX = 2;
  localparam int unsigned BBC_ST_TX       = 0;
  localparam int unsigned BBC_ST_RX       = 1;
  localparam int unsigned BBC_ST_FATTN    = 2;
  localparam logic [2:0] BBC_CTRL_RST  = 3'h0;
  localparam logic [7:0] BBC_LOWER_RST = 8'hff;
  localparam logic [7:0] BBC_UPPER_RST = 8'h00;
  localparam logic [7:0] BBC_BIAS_RST  = 8'h00;
endpackage : bbc_pkg

// ===== bbc_cfg_if.sv
`timescale 1ns/10ps
interface bbc_cfg_if;
  logic       attn;
  logic       prog_sel;
  logic       prefer_rx;
  logic [7:0] lower;
  logic [7:0] upper;
  logic [7:0] bias;
  logic       tx_busy;
  logic       rx_busy;
  logic       far_attn;
  modport regs (output attn, prog_sel, prefer_rx, lower, upper, bias,
                input tx_busy, rx_busy, far_attn);
  modport core (input attn, prog_sel, prefer_rx, lower, upper, bias,
                output tx_busy, rx_busy, far_attn);
endinterface : bbc_cfg_if

// ===== bbc_window.sv
`timescale 1ns/10ps
module bbc_window
  import bbc_pkg::*;
#(
  parameter int unsigned AW = BBC_ADDR_W
) (
  input  wire logic [AW-1:0]         i_addr,
  input  wire logic [BBC_PAGE_W-1:0] i_lower,
  input  wire logic [BBC_PAGE_W-1:0] i_upper,
  input  wire logic [BBC_PAGE_W-1:0] i_bias,
  output logic                       o_claim,
  output logic [AW-1:0]              o_addr
);
  logic [BBC_PAGE_W-1:0] page;
  logic                  pcs_hit;
  logic                  win_hit;

  always_comb begin
    page    = i_addr[AW-1 -: BBC_PAGE_W];
    pcs_hit = (i_addr[AW-1:BBC_PCS_SH] == BBC_PCS_BASE[AW-1:BBC_PCS_SH]);
    win_hit = (page >= i_lower) && (page <= i_upper);
    o_claim = pcs_hit || win_hit;
    o_addr  = i_addr;
    if (!pcs_hit) begin
      o_addr[AW-1 -: BBC_PAGE_W] = BBC_PAGE_W'(page + i_bias);
    end
  end
endmodule : bbc_window

// ===== bbc_ahb_regs.sv
`timescale 1ns/10ps
module bbc_ahb_regs
  import bbc_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic             o_hreadyout,
  output logic [31:0]      o_hrdata,
  bbc_cfg_if.regs          cfg
);
  logic       pend_r, pend_nxt, wr_r, wr_nxt, rdy_r, rdy_nxt;
  logic [7:0] off_r, off_nxt, lower_r, lower_nxt, upper_r, upper_nxt;
  logic [7:0] bias_r, bias_nxt;
  logic [2:0] ctrl_r, ctrl_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic        take;

  // ****************************************
  // One wait state so read data leave a flop.
  // ****************************************
  always_comb begin
    take      = i_hsel && i_htrans[1] && i_hready;
    pend_nxt  = take;
    wr_nxt    = take ? i_hwrite : wr_r;
    off_nxt   = take ? i_haddr[7:0] : off_r;
    rdy_nxt   = !take;
    ctrl_nxt  = ctrl_r;
    lower_nxt = lower_r;
    upper_nxt = upper_r;
    bias_nxt  = bias_r;
    rd_nxt    = rd_r;
    if (pend_r && wr_r) begin
      case (off_r)
        BBC_OFF_CTRL:  ctrl_nxt  = i_hwdata[2:0];
        BBC_OFF_LOWER: lower_nxt = i_hwdata[7:0];
        BBC_OFF_UPPER: upper_nxt = i_hwdata[7:0];
        BBC_OFF_BIAS:  bias_nxt  = i_hwdata[7:0];
        default:       ctrl_nxt  = ctrl_r;
      endcase
    end
    if (pend_r && !wr_r) begin
      case (off_r)
        BBC_OFF_CTRL:   rd_nxt = {29'h0, ctrl_r};
        BBC_OFF_LOWER:  rd_nxt = {24'h0, lower_r};
        BBC_OFF_UPPER:  rd_nxt = {24'h0, upper_r};
        BBC_OFF_BIAS:   rd_nxt = {24'h0, bias_r};
        BBC_OFF_STATUS: rd_nxt = {29'h0, cfg.far_attn, cfg.rx_busy, cfg.tx_busy};
        default:        rd_nxt = 32'h0;
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pend_r  <= 1'b0;
      wr_r    <= 1'b0;
      off_r   <= 8'h00;
      rdy_r   <= 1'b1;
      rd_r    <= 32'h0;
      ctrl_r  <= BBC_CTRL_RST;
      lower_r <= BBC_LOWER_RST;
      upper_r <= BBC_UPPER_RST;
      bias_r  <= BBC_BIAS_RST;
    end else begin
      pend_r  <= pend_nxt;
      wr_r    <= wr_nxt;
      off_r   <= off_nxt;
      rdy_r   <= rdy_nxt;
      rd_r    <= rd_nxt;
      ctrl_r  <= ctrl_nxt;
      lower_r <= lower_nxt;
      upper_r <= upper_nxt;
      bias_r  <= bias_nxt;
    end
  end

  assign o_hreadyout   = rdy_r;
  assign o_hrdata      = rd_r;
  assign cfg.attn      = ctrl_r[BBC_CTRL_ATTN];
  assign cfg.prog_sel  = ctrl_r[BBC_CTRL_PROG];
  assign cfg.prefer_rx = ctrl_r[BBC_CTRL_PREFRX];
  assign cfg.lower     = lower_r;
  assign cfg.upper     = upper_r;
  assign cfg.bias      = bias_r;

  ahb_wait_a : assert property (@(posedge i_clk) disable iff (i_rst)
    take |=> !o_hreadyout ##1 o_hreadyout)
    else $error("register bus answer not after one wait state");
  attn_write_a : assert property (@(posedge i_clk) disable iff (i_rst)
    pend_r && wr_r && off_r == BBC_OFF_CTRL |=> cfg.attn == $past(i_hwdata[0]))
    else $error("attention bit not written");
endmodule : bbc_ahb_regs

// ===== bbc_coupler.sv
`timescale 1ns/10ps
// Functional notes
// - A master holds each transfer open until the slave response arrives.
// - Masters contend by position; the higher-positioned requester wins.
// - Priority is resolved by a chain through every user, no central arbiter.
// - A master drives its address only after it has been granted the bus.
// - Data lines are two-way, 16 bits, written or read in parallel.
// - Bus addresses are 20-bit word addresses.
// - Top 1K words reserved; its first 512 form the peripheral control space.
// - The transmitter ignores bus addresses while the local receiver is active.
// - With receiver passive, claim the boundary window and the control space.
// - Windowed addresses get the bias added; control space addresses pass unchanged.
// - The receiver contends for its local bus as a master and performs it.
// - Boundaries and bias range 0 to 1020K words in 4K steps.
// - Only one cable direction at a time; a preferred direction breaks ties.
// - An idle link leaves both buses undisturbed.
// - Software sets an attention bit whose state travels to the far end.
// - Boundaries and bias may come from programmable modules instead of switches.
module bbc_coupler
  import bbc_pkg::*;
#(
  parameter int unsigned AW = BBC_ADDR_W,
  parameter int unsigned DW = BBC_DATA_W
) (
  input  wire logic                      i_clk,
  input  wire logic                      i_rst,
  input  wire logic                      i_hsel,
  input  wire logic [31:0]               i_haddr,
  input  wire logic [1:0]                i_htrans,
  input  wire logic                      i_hwrite,
  input  wire logic [2:0]                i_hsize,
  input  wire logic [31:0]               i_hwdata,
  input  wire logic                      i_hready,
  output logic                           o_hreadyout,
  output logic [31:0]                    o_hrdata,
  output logic                           o_hresp,
  input  wire logic [bbc_pkg::BBC_PAGE_W-1:0] i_sw_lower,
  input  wire logic [bbc_pkg::BBC_PAGE_W-1:0] i_sw_upper,
  input  wire logic [bbc_pkg::BBC_PAGE_W-1:0] i_sw_bias,
  input  wire logic                      i_lb_req,
  input  wire logic [AW-1:0]             i_lb_addr,
  input  wire logic                      i_lb_we,
  input  wire logic [DW-1:0]             i_lb_dat,
  output logic [DW-1:0]                  o_lb_dat,
  output logic                           o_lb_dat_oe,
  output logic                           o_lb_ack,
  input  wire logic                      i_lm_prio_in,
  input  wire logic                      i_lm_busy,
  input  wire logic                      i_lm_ack,
  input  wire logic [DW-1:0]             i_lm_dat,
  output logic                           o_lm_prio_out,
  output logic                           o_lm_breq,
  output logic                           o_lm_addr_oe,
  output logic [AW-1:0]                  o_lm_addr,
  output logic                           o_lm_we,
  output logic [DW-1:0]                  o_lm_dat,
  output logic                           o_lm_dat_oe,
  output logic                           o_tx_req,
  output logic [AW-1:0]                  o_tx_addr,
  output logic                           o_tx_we,
  output logic [DW-1:0]                  o_tx_dat,
  output logic                           o_tx_attn,
  input  wire logic                      i_tx_ack,
  input  wire logic [DW-1:0]             i_tx_dat,
  input  wire logic                      i_rx_req,
  input  wire logic [AW-1:0]             i_rx_addr,
  input  wire logic                      i_rx_we,
  input  wire logic [DW-1:0]             i_rx_dat,
  input  wire logic                      i_rx_attn,
  output logic                           o_rx_ack,
  output logic [DW-1:0]                  o_rx_dat,
  output logic                           o_attn_irq
);
  import bbc_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE, ST_TX, ST_TX_REL, ST_RX_ARB, ST_RX_XFER, ST_RX_REL
  } bbc_state_e;

  bbc_state_e st_r, st_nxt;
  logic          lb_ack_r, lb_ack_nxt, lb_oe_r, lb_oe_nxt;
  logic [DW-1:0] lb_dat_r, lb_dat_nxt;
  logic          tx_req_r, tx_req_nxt, tx_we_r, tx_we_nxt, attn_r, attn_nxt;
  logic [AW-1:0] tx_addr_r, tx_addr_nxt;
  logic [DW-1:0] tx_dat_r, tx_dat_nxt;
  logic          breq_r, breq_nxt, prio_r, prio_nxt, aoe_r, aoe_nxt;
  logic          lm_we_r, lm_we_nxt, doe_r, doe_nxt;
  logic [AW-1:0] lm_addr_r, lm_addr_nxt;
  logic [DW-1:0] lm_dat_r, lm_dat_nxt;
  logic          rx_ack_r, rx_ack_nxt, irq_r, irq_nxt;
  logic [DW-1:0] rx_dat_r, rx_dat_nxt;
  logic [BBC_PAGE_W-1:0] lower, upper, bias;
  logic          claim, gnt, go_tx, go_rx, rx_active;
  logic [AW-1:0] win_addr;

  bbc_cfg_if cfg ();

  // ****************************************
  // Register file
  // ****************************************
  bbc_ahb_regs u_regs (
    .i_clk       (i_clk),
    .i_rst       (i_rst),
    .i_hsel      (i_hsel),
    .i_haddr     (i_haddr),
    .i_htrans    (i_htrans),
    .i_hwrite    (i_hwrite),
    .i_hwdata    (i_hwdata),
    .i_hready    (i_hready),
    .o_hreadyout (o_hreadyout),
    .o_hrdata    (o_hrdata),
    .cfg         (cfg.regs)
  );

  // Only word transfers occur, so the size is not decoded.
  assign o_hresp = 1'b0;

  assign lower = cfg.prog_sel ? cfg.lower : i_sw_lower;
  assign upper = cfg.prog_sel ? cfg.upper : i_sw_upper;
  assign bias  = cfg.prog_sel ? cfg.bias  : i_sw_bias;

  bbc_window #(.AW(AW)) u_win (
    .i_addr  (i_lb_addr),
    .i_lower (lower),
    .i_upper (upper),
    .i_bias  (bias),
    .o_claim (claim),
    .o_addr  (win_addr)
  );

  // ****************************************
  // Link direction and transfer sequencing
  // ****************************************
  always_comb begin
    st_nxt      = st_r;
    lb_ack_nxt  = lb_ack_r;
    lb_oe_nxt   = lb_oe_r;
    lb_dat_nxt  = lb_dat_r;
    tx_req_nxt  = tx_req_r;
    tx_addr_nxt = tx_addr_r;
    tx_we_nxt   = tx_we_r;
    tx_dat_nxt  = tx_dat_r;
    breq_nxt    = breq_r;
    aoe_nxt     = aoe_r;
    lm_addr_nxt = lm_addr_r;
    lm_we_nxt   = lm_we_r;
    lm_dat_nxt  = lm_dat_r;
    doe_nxt     = doe_r;
    rx_ack_nxt  = rx_ack_r;
    rx_dat_nxt  = rx_dat_r;
    attn_nxt    = cfg.attn;
    irq_nxt     = i_rx_attn;
    rx_active   = (st_r == ST_RX_ARB) || (st_r == ST_RX_XFER) || (st_r == ST_RX_REL);
    // win only with no higher requester
    gnt         = !i_lm_prio_in && !i_lm_busy;
    go_rx       = i_rx_req && (cfg.prefer_rx || !(i_lb_req && claim));
    go_tx       = i_lb_req && claim && !i_tx_ack && !go_rx;
    case (st_r)
      ST_IDLE: begin
        if (go_rx) begin
          st_nxt   = ST_RX_ARB;
          breq_nxt = 1'b1;
        end else if (go_tx) begin
          st_nxt      = ST_TX;
          tx_req_nxt  = 1'b1;
          tx_addr_nxt = win_addr;
          tx_we_nxt   = i_lb_we;
          tx_dat_nxt  = i_lb_dat;
        end
      end
      ST_TX: begin
        // hold local response for far slave
        if (i_tx_ack) begin
          st_nxt     = ST_TX_REL;
          tx_req_nxt = 1'b0;
          lb_ack_nxt = 1'b1;
          lb_oe_nxt  = !tx_we_r;
          lb_dat_nxt = i_tx_dat;
        end
      end
      ST_TX_REL: begin
        if (!i_lb_req) begin
          st_nxt     = ST_IDLE;
          lb_ack_nxt = 1'b0;
          lb_oe_nxt  = 1'b0;
        end
      end
      ST_RX_ARB: begin
        if (gnt) begin
          st_nxt      = ST_RX_XFER;
          aoe_nxt     = 1'b1;
          lm_addr_nxt = i_rx_addr;
          lm_we_nxt   = i_rx_we;
          lm_dat_nxt  = i_rx_dat;
          doe_nxt     = i_rx_we;
        end
      end
      ST_RX_XFER: begin
        if (i_lm_ack) begin
          st_nxt     = ST_RX_REL;
          breq_nxt   = 1'b0;
          aoe_nxt    = 1'b0;
          doe_nxt    = 1'b0;
          rx_ack_nxt = 1'b1;
          rx_dat_nxt = lm_we_r ? rx_dat_r : i_lm_dat;
        end
      end
      ST_RX_REL: begin
        if (!i_rx_req) begin
          st_nxt     = ST_IDLE;
          rx_ack_nxt = 1'b0;
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
    prio_nxt = i_lm_prio_in || breq_nxt;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_r      <= ST_IDLE;
      lb_ack_r  <= 1'b0;
      lb_oe_r   <= 1'b0;
      lb_dat_r  <= '0;
      tx_req_r  <= 1'b0;
      tx_addr_r <= '0;
      tx_we_r   <= 1'b0;
      tx_dat_r  <= '0;
      attn_r    <= 1'b0;
      breq_r    <= 1'b0;
      prio_r    <= 1'b0;
      aoe_r     <= 1'b0;
      lm_addr_r <= '0;
      lm_we_r   <= 1'b0;
      lm_dat_r  <= '0;
      doe_r     <= 1'b0;
      rx_ack_r  <= 1'b0;
      rx_dat_r  <= '0;
      irq_r     <= 1'b0;
    end else begin
      st_r      <= st_nxt;
      lb_ack_r  <= lb_ack_nxt;
      lb_oe_r   <= lb_oe_nxt;
      lb_dat_r  <= lb_dat_nxt;
      tx_req_r  <= tx_req_nxt;
      tx_addr_r <= tx_addr_nxt;
      tx_we_r   <= tx_we_nxt;
      tx_dat_r  <= tx_dat_nxt;
      attn_r    <= attn_nxt;
      breq_r    <= breq_nxt;
      prio_r    <= prio_nxt;
      aoe_r     <= aoe_nxt;
      lm_addr_r <= lm_addr_nxt;
      lm_we_r   <= lm_we_nxt;
      lm_dat_r  <= lm_dat_nxt;
      doe_r     <= doe_nxt;
      rx_ack_r  <= rx_ack_nxt;
      rx_dat_r  <= rx_dat_nxt;
      irq_r     <= irq_nxt;
    end
  end

  assign cfg.tx_busy  = (st_r == ST_TX) || (st_r == ST_TX_REL);
  assign cfg.rx_busy  = rx_active;
  assign cfg.far_attn = irq_r;

  assign o_lb_ack      = lb_ack_r;
  assign o_lb_dat_oe   = lb_oe_r;
  assign o_lb_dat      = lb_dat_r;
  assign o_tx_req      = tx_req_r;
  assign o_tx_addr     = tx_addr_r;
  assign o_tx_we       = tx_we_r;
  assign o_tx_dat      = tx_dat_r;
  assign o_tx_attn     = attn_r;
  assign o_lm_breq     = breq_r;
  assign o_lm_prio_out = prio_r;
  assign o_lm_addr_oe  = aoe_r;
  assign o_lm_addr     = lm_addr_r;
  assign o_lm_we       = lm_we_r;
  assign o_lm_dat      = lm_dat_r;
  assign o_lm_dat_oe   = doe_r;
  assign o_rx_ack      = rx_ack_r;
  assign o_rx_dat      = rx_dat_r;
  assign o_attn_irq    = irq_r;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence s_lm_done;
    o_lm_addr_oe && i_lm_ack;
  endsequence

  one_dir_a : assert property (!(o_tx_req && o_lm_breq))
    else $error("both cable directions active");
  tx_ignore_a : assert property (rx_active |=> !$rose(o_tx_req))
    else $error("transmitter claimed while receiver active");
  bias_fwd_a : assert property ($rose(o_tx_req) |-> o_tx_addr == $past(win_addr))
    else $error("forwarded address not biased as set");
  addr_hold_a : assert property (o_tx_req && $past(o_tx_req) |-> $stable(o_tx_addr))
    else $error("forwarded address moved");
  resp_wait_a : assert property ($rose(o_lb_ack) |-> $past(i_tx_ack) && $past(o_tx_req))
    else $error("local response before far response");
  read_data_a : assert property ($rose(o_lb_ack) && o_lb_dat_oe |-> o_lb_dat == $past(i_tx_dat))
    else $error("read data not the far word");
  grant_first_a : assert property ($rose(o_lm_addr_oe) |-> $past(gnt) && $past(o_lm_breq))
    else $error("address driven without grant");
  prio_pass_a : assert property (i_lm_prio_in |=> o_lm_prio_out)
    else $error("priority not passed down");
  idle_quiet_a : assert property (!o_lm_breq |-> !o_lm_addr_oe && !o_lm_dat_oe)
    else $error("bus driven while idle");
  rx_finish_a : assert property (s_lm_done |=> !o_lm_addr_oe && o_rx_ack && !o_lm_breq)
    else $error("far transfer not completed");
endmodule : bbc_coupler

// ===== bbc_far_model.sv
`timescale 1ns/10ps
// ****************************************
// Far end of the cable
// ****************************************
module bbc_far_model (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_req,
  input  wire logic [19:0] i_addr,
  input  wire logic [3:0]  i_delay,
  output logic             o_ack,
  output logic [15:0]      o_dat
);
  logic [3:0] cnt_r;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_r <= 4'h0;
      o_ack <= 1'b0;
      o_dat <= 16'h0;
    end else if (!i_req) begin
      // Released data flips every cycle, so a stale word cannot pass.
      cnt_r <= 4'h0;
      o_ack <= 1'b0;
      o_dat <= ~o_dat;
    end else if (cnt_r < i_delay) begin
      cnt_r <= cnt_r + 4'h1;
      o_dat <= ~o_dat;
    end else begin
      o_ack <= 1'b1;
      o_dat <= i_addr[15:0] ^ 16'h5a5a;
    end
  end
endmodule : bbc_far_model

// ===== test_backplane_bus_coupler.sv
`timescale 1ns/10ps
module test_backplane_bus_coupler;
  import bbc_pkg::*;
  logic        i_clk, i_rst, i_hsel, i_hwrite, i_lb_req, i_lb_we, i_lm_prio_in, i_lm_busy, i_lm_ack;
  logic        i_rx_req, i_rx_we, i_rx_attn, i_tx_ack, o_hreadyout, o_hresp, o_lb_dat_oe, o_lb_ack;
  logic        o_lm_prio_out, o_lm_breq, o_lm_addr_oe, o_lm_we, o_lm_dat_oe, o_tx_req, o_tx_we;
  logic        o_tx_attn, o_rx_ack, o_attn_irq, i_hready;
  logic [1:0]  i_htrans;
  logic [2:0]  i_hsize;
  logic [3:0]  i_delay;
  logic [7:0]  i_sw_lower, i_sw_upper, i_sw_bias, lo, up, bi;
  logic [15:0] i_lb_dat, o_lb_dat, i_lm_dat, o_lm_dat, o_tx_dat, i_tx_dat, i_rx_dat, o_rx_dat;
  logic [19:0] i_lb_addr, o_lm_addr, o_tx_addr, i_rx_addr;
  logic [31:0] i_haddr, i_hwdata, o_hrdata, rd;
  logic [7:0]  rv [5] = '{8'h00, 8'hff, 8'h00, 8'h00, 8'h00};
  int          fails, check_count;

  assign i_hready = o_hreadyout;
  bbc_coupler dut (.i_clk, .i_rst, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hsize, .i_hwdata,
    .i_hready, .o_hreadyout, .o_hrdata, .o_hresp, .i_sw_lower, .i_sw_upper, .i_sw_bias, .i_lb_req,
    .i_lb_addr, .i_lb_we, .i_lb_dat, .o_lb_dat, .o_lb_dat_oe, .o_lb_ack, .i_lm_prio_in, .i_lm_busy,
    .i_lm_ack, .i_lm_dat, .o_lm_prio_out, .o_lm_breq, .o_lm_addr_oe, .o_lm_addr, .o_lm_we, .o_lm_dat,
    .o_lm_dat_oe, .o_tx_req, .o_tx_addr, .o_tx_we, .o_tx_dat, .o_tx_attn, .i_tx_ack, .i_tx_dat,
    .i_rx_req, .i_rx_addr, .i_rx_we, .i_rx_dat, .i_rx_attn, .o_rx_ack, .o_rx_dat, .o_attn_irq);
  bbc_far_model far (.i_clk, .i_rst, .i_req(o_tx_req), .i_addr(o_tx_addr), .i_delay,
    .o_ack(i_tx_ack), .o_dat(i_tx_dat));

  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic test_done;
    $display("checks=%0d fails=%0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : test_done

  function automatic logic sig(input int k);
    case (k)
      0: return o_tx_req;
      1: return o_lb_ack;
      2: return o_lm_addr_oe;
      3: return o_rx_ack;
      default: return o_lm_breq;
    endcase
  endfunction : sig

  // Every wait is bounded so that a hung handshake ends the run.
  task automatic wt(input int k, input logic v);
    int n;
    n = 0;
    while (sig(k) !== v) begin
      @(posedge i_clk);
      n++;
      if (n > 80) begin
        fails++;
        test_done;
      end
    end
  endtask : wt

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
    int n;
    n = 0;
    i_htrans <= 2'h2;
    i_haddr <= {24'h0, a};
    i_hwrite <= w;
    do begin @(posedge i_clk); n++; end while (o_hreadyout !== 1'b1 && n < 50);
    i_htrans <= 2'h0;
    i_hwdata <= wd;
    do begin @(posedge i_clk); n++; end while (o_hreadyout !== 1'b1 && n < 50);
    r = o_hrdata;
    if (n >= 50) begin
      fails++;
      test_done;
    end
  endtask : ahb

  function automatic logic fwd(input logic [19:0] a, output logic [19:0] f);
    logic pcs;
    pcs = (a[19:9] == 11'h7fe);
    f = pcs ? a : {a[19:12] + bi, a[11:0]};
    return pcs || (a[19:12] >= lo && a[19:12] <= up);
  endfunction : fwd

  function automatic logic [19:0] pick();
    logic [19:0] a;
    a = 20'($urandom);
    case ($urandom % 4)
      0: a[19:12] = lo;
      1: a[19:12] = up;
      2: a[19:9] = 11'h7fe;
      default: ;
    endcase
    return a;
  endfunction : pick

  task automatic lb(input logic [19:0] a, input logic w);
    logic [19:0] f;
    logic        c;
    c = fwd(a, f);
    i_lb_req <= 1'b1;
    i_lb_addr <= a;
    i_lb_we <= w;
    i_lb_dat <= 16'($urandom);
    i_delay <= 4'($urandom);
    if (!c) begin
      repeat (6) @(posedge i_clk);
      chk({o_tx_req, o_lb_ack}, 32'h0);
    end else begin
      wt(0, 1'b1);
      chk({o_tx_addr, o_tx_we, o_lb_ack}, {f, w, 1'b0});
      if (w) chk(o_tx_dat, i_lb_dat);
      wt(1, 1'b1);
      chk(o_lb_dat_oe, !w);
      if (!w) chk(o_lb_dat, f[15:0] ^ 16'h5a5a);
    end
    i_lb_req <= 1'b0;
    @(posedge i_clk);
    wt(1, 1'b0);
  endtask : lb

  task automatic rx(input logic w);
    logic [19:0] a;
    a = 20'($urandom);
    i_rx_req <= 1'b1;
    i_rx_addr <= a;
    i_rx_we <= w;
    i_rx_dat <= 16'($urandom);
    {i_lm_prio_in, i_lm_busy} <= {1'($urandom), 1'b1};
    // A claimed local request meets the cable request at the same edge.
    i_lb_req <= 1'b1;
    i_lb_addr <= 20'hffc00;
    wt(4, 1'b1);
    repeat (4) @(posedge i_clk);
    chk({o_lm_addr_oe, o_lm_prio_out, o_tx_req}, 32'h2);
    {i_lm_prio_in, i_lm_busy} <= 2'h0;
    wt(2, 1'b1);
    chk({o_lm_addr, o_lm_we, o_lm_dat_oe}, {a, w, w});
    if (w) chk(o_lm_dat, i_rx_dat);
    i_lm_ack <= 1'b1;
    i_lm_dat <= 16'($urandom);
    wt(3, 1'b1);
    if (!w) chk(o_rx_dat, i_lm_dat);
    chk(o_tx_req, 1'b0);
    i_rx_req <= 1'b0;
    i_lm_ack <= 1'b0;
    i_lm_dat <= ~i_lm_dat;
    i_lb_req <= 1'b0;
    wt(3, 1'b0);
  endtask : rx

  // ****************************************
  // Sequence
  // ****************************************
  initial i_clk = 1'b0;
  always #5 i_clk = ~i_clk;

  always @(negedge i_clk) begin
    if (!i_rst && o_tx_req === 1'b1) chk(o_lm_addr_oe, 1'b0);
  end

  initial begin
    {i_rst, i_hsel, i_hsize} = {1'b1, 1'b1, 3'h2};
    {i_htrans, i_haddr, i_hwrite, i_hwdata, i_delay} = '0;
    {i_sw_lower, i_sw_upper, i_sw_bias, i_lb_req, i_lb_addr, i_lb_we, i_lb_dat} = '0;
    {i_lm_prio_in, i_lm_busy, i_lm_ack, i_lm_dat, i_rx_attn} = '0;
    {i_rx_req, i_rx_addr, i_rx_we, i_rx_dat} = '0;
    void'($urandom(32'h3ba7));
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    chk({o_hreadyout, o_hresp, o_lm_addr_oe, o_lm_dat_oe, o_lb_dat_oe, o_lm_breq}, 32'h20);
    for (int i = 0; i < 5; i++) begin
      ahb(1'b0, 8'(i * 4), 32'h0, rd);
      chk(rd, {24'h0, rv[i]});
    end
    for (int r = 0; r < 4; r++) begin
      lo = 8'($urandom);
      up = lo + 8'($urandom % 12);
      bi = 8'($urandom);
      i_sw_lower <= (r == 0) ? lo : ~lo;
      i_sw_upper <= up;
      i_sw_bias <= bi;
      if (r > 0) begin
        ahb(1'b1, BBC_OFF_CTRL, 32'h2, rd);
        ahb(1'b1, BBC_OFF_LOWER, {24'h0, lo}, rd);
        ahb(1'b1, BBC_OFF_UPPER, {24'h0, up}, rd);
        ahb(1'b1, BBC_OFF_BIAS, {24'h0, bi}, rd);
        ahb(1'b0, BBC_OFF_BIAS, 32'h0, rd);
        chk(rd, {24'h0, bi});
      end
      for (int k = 0; k < 12; k++) lb(pick(), 1'($urandom));
    end
    for (int v = 1; v >= 0; v--) begin
      ahb(1'b1, BBC_OFF_CTRL, {30'h0, 1'b1, v[0]}, rd);
      i_rx_attn <= v[0];
      repeat (3) @(posedge i_clk);
      chk({o_tx_attn, o_attn_irq}, {2{v[0]}});
      ahb(1'b0, BBC_OFF_STATUS, 32'h0, rd);
      chk(rd, {29'h0, v[0], 2'h0});
    end
    ahb(1'b1, BBC_OFF_CTRL, 32'h6, rd);
    rx(1'b0);
    rx(1'b1);
    test_done;
  end
endmodule : test_backplane_bus_coupler
